// file: dsmc_pkg.sv
// Package with register map, field positions and timing constants of the mode configuration bank
`default_nettype none
package dsmc_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_PROTOCOL_REVISION = 8'h10;
  localparam logic [7:0] ADDR_SLAVE_BUS_ADDRESS = 8'h11;
  localparam logic [7:0] ADDR_DIAG_MODE_CONFIG = 8'h12;
  localparam logic [7:0] ADDR_COMMAND_MODE_CONFIG = 8'h13;
  localparam logic [7:0] ADDR_PERIODIC_MODE_ENABLE = 8'h15;
  localparam logic [7:0] ADDR_PERIODIC_PERIOD = 8'h17;
  // Fixed read-only value of the protocol revision; the value is arbitrary, set it per product
  localparam logic [7:0] PROTOCOL_REVISION_VAL = 8'hA5;
  // Reset values
  localparam logic [3:0] SLAVE_ADDR_RST = 4'h0;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [2:0] PERIOD_SEL_RST = 3'h0;
  // Field positions
  localparam int DIAG_EN_BIT = 0;
  localparam int SAMPLE_SEL_BIT = 0;
  localparam int TRAIN_EN_BIT = 1;
  localparam int CMD_PER_LSB = 2;
  localparam int TRAIN_RST_BIT = 4;
  localparam int PERIODIC_EN_BIT = 7;
  localparam int ADDR_W = 4;
  localparam int CMD_CFG_W = 5;
  // Diagnostic command fragment length when enabled
  localparam logic [2:0] DIAG_FRAG_LEN = 3'h4;
  // Periodic period per code, in microseconds
  localparam int PERIOD_US_0 = 500;
  localparam int PERIOD_US_1 = 125;
  localparam int PERIOD_US_2 = 250;
  localparam int PERIOD_US_3 = 333;
  localparam int PERIOD_US_4 = 500;
  localparam int PERIOD_US_5 = 1000;
  localparam int PERIOD_US_6 = 2000;
  localparam int PERIOD_US_7 = 4000;
  // Clock rate and derived cycles per microsecond
  localparam int CLK_MHZ = 50;
  localparam int CYC_PER_US = CLK_MHZ;
  // Training state
  typedef enum logic [1:0] {
    DSMC_TR_UNTRAINED = 2'b00,
    DSMC_TR_HOLD = 2'b01,
    DSMC_TR_ACTIVE = 2'b10
  } dsmc_train_e;
endpackage : dsmc_pkg
`default_nettype wire

// file: dsmc_regs.sv
// Mode configuration register bank of a bus slave sensor
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Read-only protocol revision, writes ignored
// - Four-bit slave address, upper bits zero
// - Address zero: obtain address by discovery
// - Nonzero address: skip discovery, use it
// - Address writable; lock restores OTP on reset
// - Diagnostic enable bit 0, fragment length 4
// - Command config field layout, upper bits zero
// - Command period codes mean 1,2,4,8
// - Period only affects training when enabled
// - Training off, reset clear: hold value
// - Training off, reset set: untrained value
// - Training on: train, ignore reset bit
// - Sample bit clear: latency from response start
// - Sample bit set: latency from command edge
// - Periodic enable bit 7, others zero
// - Enable set by command or write
// - Periodic on: lock config, start integrity check
// - Periodic enable cleared only by reset
// - Mode selection table from both enables
// - Periodic period code to microseconds
module dsmc_regs (
  input wire logic i_clk, // Core clock, 50 MHz
  input wire logic i_rst, // Asynchronous reset, active high
  input wire logic i_wr_en, // Register write strobe from command decoder
  input wire logic [7:0] i_addr, // Register address
  input wire logic [7:0] i_wdata, // Write data
  input wire logic [7:0] i_rd_addr, // Read address
  input wire logic i_enter_periodic, // Enter periodic mode command pulse
  input wire logic i_lock_user, // User lock bit from OTP
  input wire logic [3:0] i_otp_addr, // OTP slave address
  input wire logic i_train_update, // Trainer has a new adjustment
  input wire logic [7:0] i_train_value, // New trained adjustment
  input wire logic [7:0] i_train_untrained, // Untrained adjustment value
  output logic [7:0] o_rdata, // Read data
  output logic o_discovery_en, // Discovery procedure allowed
  output logic [3:0] o_slave_addr, // Active slave address
  output logic o_command_mode, // Command-and-response mode active
  output logic o_periodic_mode, // Periodic mode active
  output logic o_diag_mode, // Background diagnostics active
  output logic [2:0] o_diag_frag_len, // Diagnostic fragment length, 0 when the diagnostic enable bit is clear
  output logic [3:0] o_cmd_period_mult, // Command period as periodic multiples
  output logic o_train_active, // Oscillator training running
  output logic [7:0] o_osc_adjust, // Oscillator adjustment
  output logic o_sample_at_cmd, // Latency referenced to command edge
  output logic [12:0] o_train_period_us, // Periodic period for training, in us
  output logic o_cfg_locked, // Configuration locked
  output logic o_integrity_en // Read/write array check enabled
);
  ////////////////////////////////////////////////////////////////////////
  // Register state
  logic [3:0] addr_r, addr_nxt;
  logic diag_en_r, diag_en_nxt;
  localparam int CMD_CFG_W_L = dsmc_pkg::CMD_CFG_W;
  logic [CMD_CFG_W_L-1:0] cmd_cfg_r, cmd_cfg_nxt;
  logic periodic_en_r, periodic_en_nxt;
  logic [2:0] per_sel_r, per_sel_nxt;
  logic [7:0] osc_r, osc_nxt;
  dsmc_pkg::dsmc_train_e train_st_r, train_st_nxt;
  logic lock_seen_r, lock_seen_nxt;
  logic [7:0] rdata_nxt;
  logic wr_addr, wr_diag, wr_cmd, wr_per, wr_pen;
  logic train_en, train_rst;

  // Write decode; locked registers refuse writes once periodic mode is on
  always_comb begin
    wr_addr = i_wr_en && i_addr == dsmc_pkg::ADDR_SLAVE_BUS_ADDRESS && !periodic_en_r;
    wr_diag = i_wr_en && i_addr == dsmc_pkg::ADDR_DIAG_MODE_CONFIG && !periodic_en_r;
    wr_cmd = i_wr_en && i_addr == dsmc_pkg::ADDR_COMMAND_MODE_CONFIG && !periodic_en_r;
    wr_per = i_wr_en && i_addr == dsmc_pkg::ADDR_PERIODIC_PERIOD && !periodic_en_r;
    wr_pen = i_wr_en && i_addr == dsmc_pkg::ADDR_PERIODIC_MODE_ENABLE;
    train_en = cmd_cfg_r[dsmc_pkg::TRAIN_EN_BIT];
    train_rst = cmd_cfg_r[dsmc_pkg::TRAIN_RST_BIT];
  end

  // Next values of configuration; the lock strap is applied once after reset release
  always_comb begin
    addr_nxt = addr_r;
    diag_en_nxt = diag_en_r;
    cmd_cfg_nxt = cmd_cfg_r;
    per_sel_nxt = per_sel_r;
    periodic_en_nxt = periodic_en_r;
    lock_seen_nxt = 1'b1;
    if (!lock_seen_r && i_lock_user) begin
      addr_nxt = i_otp_addr;
    end else if (wr_addr) begin
      addr_nxt = i_wdata[dsmc_pkg::ADDR_W-1:0];
    end
    if (wr_diag) begin
      diag_en_nxt = i_wdata[dsmc_pkg::DIAG_EN_BIT];
    end
    if (wr_cmd) begin
      cmd_cfg_nxt = i_wdata[CMD_CFG_W_L-1:0];
    end
    if (wr_per) begin
      per_sel_nxt = i_wdata[2:0];
    end
    // Sticky: either path sets it, nothing but reset clears it
    if (i_enter_periodic || (wr_pen && i_wdata[dsmc_pkg::PERIODIC_EN_BIT])) begin
      periodic_en_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      addr_r <= dsmc_pkg::SLAVE_ADDR_RST;
      diag_en_r <= 1'b0;
      cmd_cfg_r <= '0;
      per_sel_r <= dsmc_pkg::PERIOD_SEL_RST;
      periodic_en_r <= 1'b0;
      lock_seen_r <= 1'b0;
    end else begin
      addr_r <= addr_nxt;
      diag_en_r <= diag_en_nxt;
      cmd_cfg_r <= cmd_cfg_nxt;
      per_sel_r <= per_sel_nxt;
      periodic_en_r <= periodic_en_nxt;
      lock_seen_r <= lock_seen_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Oscillator adjustment and training status; training wins over the reset bit
  always_comb begin
    osc_nxt = osc_r;
    train_st_nxt = train_st_r;
    if (train_en) begin
      if (i_train_update) begin
        osc_nxt = i_train_value;
      end
    end else if (train_rst) begin
      osc_nxt = i_train_untrained;
    end
    // Status follows the two control bits; a held value survives until the reset bit is set
    case (train_st_r)
      dsmc_pkg::DSMC_TR_UNTRAINED: begin
        if (train_en) begin
          train_st_nxt = dsmc_pkg::DSMC_TR_ACTIVE;
        end
      end
      dsmc_pkg::DSMC_TR_HOLD: begin
        if (train_en) begin
          train_st_nxt = dsmc_pkg::DSMC_TR_ACTIVE;
        end else if (train_rst) begin
          train_st_nxt = dsmc_pkg::DSMC_TR_UNTRAINED;
        end
      end
      dsmc_pkg::DSMC_TR_ACTIVE: begin
        if (!train_en && train_rst) begin
          train_st_nxt = dsmc_pkg::DSMC_TR_UNTRAINED;
        end else if (!train_en) begin
          train_st_nxt = dsmc_pkg::DSMC_TR_HOLD;
        end
      end
      default: begin
        train_st_nxt = train_en ? dsmc_pkg::DSMC_TR_ACTIVE : dsmc_pkg::DSMC_TR_UNTRAINED;
      end
    endcase
  end

  // Adjustment resets to zero; the untrained value comes only via the reset bit, the trainer loads the trained value
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      osc_r <= 8'h00;
      train_st_r <= dsmc_pkg::DSMC_TR_UNTRAINED;
    end else begin
      osc_r <= osc_nxt;
      train_st_r <= train_st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses read zero
  always_comb begin
    case (i_rd_addr)
      dsmc_pkg::ADDR_PROTOCOL_REVISION: rdata_nxt = dsmc_pkg::PROTOCOL_REVISION_VAL;
      dsmc_pkg::ADDR_SLAVE_BUS_ADDRESS: rdata_nxt = {4'h0, addr_r};
      dsmc_pkg::ADDR_DIAG_MODE_CONFIG: rdata_nxt = {7'h00, diag_en_r};
      dsmc_pkg::ADDR_COMMAND_MODE_CONFIG: rdata_nxt = {3'h0, cmd_cfg_r};
      dsmc_pkg::ADDR_PERIODIC_MODE_ENABLE: rdata_nxt = {periodic_en_r, 7'h00};
      dsmc_pkg::ADDR_PERIODIC_PERIOD: rdata_nxt = {5'h00, per_sel_r};
      default: rdata_nxt = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs derived from configuration
  logic [3:0] mult;
  logic [12:0] per_us;
  logic disc_nxt;
  logic [3:0] slave_addr_nxt;
  logic cmd_mode_nxt;
  logic per_mode_nxt;
  logic diag_mode_nxt;
  logic [2:0] frag_len_nxt;
  logic train_act_nxt;
  logic [7:0] osc_out_nxt;
  logic sample_nxt;
  logic [12:0] train_per_nxt;
  logic locked_nxt;
  logic integ_nxt;
  // Next output values; the period lookup is only published while training runs
  always_comb begin
    case (cmd_cfg_r[dsmc_pkg::CMD_PER_LSB +: 2])
      2'b00: mult = 4'h1;
      2'b01: mult = 4'h2;
      2'b10: mult = 4'h4;
      default: mult = 4'h8;
    endcase
    case (per_sel_r)
      3'h0: per_us = 13'(dsmc_pkg::PERIOD_US_0);
      3'h1: per_us = 13'(dsmc_pkg::PERIOD_US_1);
      3'h2: per_us = 13'(dsmc_pkg::PERIOD_US_2);
      3'h3: per_us = 13'(dsmc_pkg::PERIOD_US_3);
      3'h4: per_us = 13'(dsmc_pkg::PERIOD_US_4);
      3'h5: per_us = 13'(dsmc_pkg::PERIOD_US_5);
      3'h6: per_us = 13'(dsmc_pkg::PERIOD_US_6);
      default: per_us = 13'(dsmc_pkg::PERIOD_US_7);
    endcase
    disc_nxt = addr_r == 4'h0;
    slave_addr_nxt = addr_r;
    cmd_mode_nxt = !periodic_en_r;
    per_mode_nxt = periodic_en_r;
    diag_mode_nxt = periodic_en_r && diag_en_r;
    frag_len_nxt = diag_en_r ? dsmc_pkg::DIAG_FRAG_LEN : 3'h0;
    train_act_nxt = train_st_nxt == dsmc_pkg::DSMC_TR_ACTIVE;
    osc_out_nxt = osc_r;
    sample_nxt = cmd_cfg_r[dsmc_pkg::SAMPLE_SEL_BIT];
    train_per_nxt = train_en ? per_us : 13'h0000;
    locked_nxt = periodic_en_r;
    integ_nxt = periodic_en_r;
  end

  // Outputs lag their source registers by one cycle, except o_train_active, which is taken from the next training state
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
      o_discovery_en <= 1'b1;
      o_slave_addr <= 4'h0;
      o_command_mode <= 1'b1;
      o_periodic_mode <= 1'b0;
      o_diag_mode <= 1'b0;
      o_diag_frag_len <= 3'h0;
      o_cmd_period_mult <= 4'h1;
      o_train_active <= 1'b0;
      o_osc_adjust <= 8'h00;
      o_sample_at_cmd <= 1'b0;
      o_train_period_us <= 13'h0000;
      o_cfg_locked <= 1'b0;
      o_integrity_en <= 1'b0;
    end else begin
      o_rdata <= rdata_nxt;
      o_discovery_en <= disc_nxt;
      o_slave_addr <= slave_addr_nxt;
      o_command_mode <= cmd_mode_nxt;
      o_periodic_mode <= per_mode_nxt;
      o_diag_mode <= diag_mode_nxt;
      o_diag_frag_len <= frag_len_nxt;
      o_cmd_period_mult <= mult;
      o_train_active <= train_act_nxt;
      o_osc_adjust <= osc_out_nxt;
      o_sample_at_cmd <= sample_nxt;
      o_train_period_us <= train_per_nxt;
      o_cfg_locked <= locked_nxt;
      o_integrity_en <= integ_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  periodic_sticky_a: assert property (@(posedge i_clk) disable iff (i_rst)
    periodic_en_r |=> periodic_en_r) else $error("periodic enable cleared");
  locked_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
    periodic_en_r && i_wr_en |=> $stable(cmd_cfg_r) && $stable(diag_en_r) && $stable(addr_r)
    && $stable(per_sel_r)) else $error("locked reg changed");
  enter_cmd_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_enter_periodic |-> ##2 o_periodic_mode && !o_command_mode) else $error("enter command ignored");
  revision_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rd_addr == dsmc_pkg::ADDR_PROTOCOL_REVISION |=> o_rdata == dsmc_pkg::PROTOCOL_REVISION_VAL)
    else $error("revision wrong");
  diag_gate_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_diag_mode |-> o_periodic_mode && $past(diag_en_r)) else $error("diag without periodic");
  train_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !train_en && !train_rst |=> $stable(osc_r)) else $error("adjustment drifted");
  train_reset_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !train_en && train_rst |=> osc_r == $past(i_train_untrained)) else $error("untrained not restored");
  train_run_a: assert property (@(posedge i_clk) disable iff (i_rst)
    train_en && i_train_update |=> osc_r == $past(i_train_value)) else $error("training ignored");
  addr_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_addr && lock_seen_r |=> ##1 o_slave_addr == $past(i_wdata[3:0], 2)) else $error("address not written");
  addr_upper_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rd_addr == dsmc_pkg::ADDR_SLAVE_BUS_ADDRESS |=> o_rdata[7:4] == 4'h0) else $error("address high bits");
  cmd_upper_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rd_addr == dsmc_pkg::ADDR_COMMAND_MODE_CONFIG |=> o_rdata[7:5] == 3'h0) else $error("command cfg high bits");
  enable_bits_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rd_addr == dsmc_pkg::ADDR_PERIODIC_MODE_ENABLE |=> o_rdata[6:0] == 7'h00) else $error("enable low bits");
  frag_len_a: assert property (@(posedge i_clk) disable iff (i_rst)
    diag_en_r |=> o_diag_frag_len == dsmc_pkg::DIAG_FRAG_LEN) else $error("fragment length wrong");
  period_mult_a: assert property (@(posedge i_clk) disable iff (i_rst)
    cmd_cfg_r[dsmc_pkg::CMD_PER_LSB +: 2] == 2'b11 |=> o_cmd_period_mult == 4'h8) else $error("multiple wrong");
  train_period_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !train_en |=> o_train_period_us == 13'h0000) else $error("period shown while idle");
  cfg_lock_a: assert property (@(posedge i_clk) disable iff (i_rst)
    periodic_en_r |=> o_cfg_locked && o_integrity_en) else $error("lock not applied");
  discovery_a: assert property (@(posedge i_clk) disable iff (i_rst)
    addr_r == 4'h0 |=> o_discovery_en) else $error("discovery not allowed");
  programmed_addr_a: assert property (@(posedge i_clk) disable iff (i_rst)
    addr_r != 4'h0 |=> !o_discovery_en && o_slave_addr == $past(addr_r)) else $error("programmed address unused");
  sample_sel_a: assert property (@(posedge i_clk) disable iff (i_rst)
    cmd_cfg_r[dsmc_pkg::SAMPLE_SEL_BIT] |=> o_sample_at_cmd) else $error("sample method ignored");
  train_status_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !train_en && train_rst |=> train_st_r == dsmc_pkg::DSMC_TR_UNTRAINED) else $error("status not untrained");
endmodule : dsmc_regs
`default_nettype wire

// file: dsmc_master_model.sv
// Bus master model that issues register writes, reads and the enter command
`timescale 1ns/1ps
`default_nettype none
module dsmc_master_model (
  input wire logic i_clk, // Core clock
  input wire logic [7:0] i_rdata, // Read data from the bank
  output logic o_wr_en, // Write strobe
  output logic [7:0] o_addr, // Write address
  output logic [7:0] o_wdata, // Write data
  output logic [7:0] o_rd_addr, // Read address
  output logic o_enter // Enter periodic command pulse
);
  ////////////////////////////////////////////////////////////////////////
  // Idle values; callers enter the tasks just after a rising edge
  initial begin
    o_wr_en = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_rd_addr = 8'h00;
    o_enter = 1'b0;
  end
  // Register write, held until the taking edge, then the data is scrambled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    o_addr = a;
    o_wdata = d;
    o_wr_en = 1'b1;
    @(posedge i_clk);
    #1;
    o_wr_en = 1'b0;
    o_wdata = ~d;
  endtask : wr
  // Enter periodic command as a one-cycle pulse
  task automatic enter();
    o_enter = 1'b1;
    @(posedge i_clk);
    #1;
    o_enter = 1'b0;
  endtask : enter
  // Read: address as a level, data taken one edge later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    o_rd_addr = a;
    @(posedge i_clk);
    #1;
    d = i_rdata;
  endtask : rd
endmodule : dsmc_master_model
`default_nettype wire

// file: testbench.sv
// Self-checking testbench of the mode configuration bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_clk = 1'b0, i_rst = 1'b1, wr_en, enter, i_lock_user = 1'b0, i_train_update = 1'b0;
  logic [7:0] addr, wdata, rd_addr, rdata, i_train_value = 8'h33, i_train_untrained = 8'h5A, v;
  logic [3:0] i_otp_addr = 4'h9, slave_addr, mult;
  logic disc, cmd_m, per_m, diag_m, tr_act, smp, locked, integ;
  logic [2:0] frag;
  logic [7:0] osc;
  logic [12:0] per_us;
  int fail_count = 0, num_checks = 0;
  // 50 MHz clock
  always #10 i_clk = ~i_clk;
  dsmc_master_model u_m (.i_clk(i_clk), .i_rdata(rdata), .o_wr_en(wr_en), .o_addr(addr),
    .o_wdata(wdata), .o_rd_addr(rd_addr), .o_enter(enter));
  dsmc_regs u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_wr_en(wr_en), .i_addr(addr), .i_wdata(wdata),
    .i_rd_addr(rd_addr), .i_enter_periodic(enter), .i_lock_user(i_lock_user), .i_otp_addr(i_otp_addr),
    .i_train_update(i_train_update), .i_train_value(i_train_value), .i_train_untrained(i_train_untrained),
    .o_rdata(rdata), .o_discovery_en(disc), .o_slave_addr(slave_addr), .o_command_mode(cmd_m),
    .o_periodic_mode(per_m), .o_diag_mode(diag_m), .o_diag_frag_len(frag), .o_cmd_period_mult(mult),
    .o_train_active(tr_act), .o_osc_adjust(osc), .o_sample_at_cmd(smp), .o_train_period_us(per_us),
    .o_cfg_locked(locked), .o_integrity_en(integ));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Write, then let the derived outputs settle
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    u_m.wr(a, d);
    repeat (2) @(posedge i_clk);
    #1;
  endtask : w
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    u_m.rd(a, v);
    chk({5'h00, v}, {5'h00, exp});
  endtask : rchk
  // Reset held three cycles, plus two edges: one that may load the strap address, one that registers the outputs
  task automatic do_reset();
    i_rst = 1'b1;
    repeat (3) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
  endtask : do_reset
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  // Watchdog: the sequence takes under a hundred cycles
  initial begin
    #200000;
    fail_count++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    chk({disc, cmd_m, per_m, mult}, {1'b1, 1'b1, 1'b0, 4'h1});
    rchk(8'h10, dsmc_pkg::PROTOCOL_REVISION_VAL);
    rchk(8'h14, 8'h00);
    w(8'h10, 8'hFF);
    rchk(8'h10, dsmc_pkg::PROTOCOL_REVISION_VAL);
    w(8'h11, 8'hFF);
    rchk(8'h11, 8'h0F);
    chk({disc, slave_addr}, {1'b0, 4'hF});
    w(8'h11, 8'h00);
    chk({disc, slave_addr}, {1'b1, 4'h0});
    $display("Test address and revision done");
    // Period multiple codes with the training bit set
    for (int c = 0; c < 4; c++) begin
      w(8'h13, {4'h0, c[1:0], 2'b11});
      chk(mult, 4'h1 << c);
      chk({tr_act, smp}, 2'b11);
    end
    w(8'h13, 8'hFF);
    rchk(8'h13, 8'h1F);
    w(8'h13, 8'h10);
    chk({tr_act, smp, osc}, {2'b00, 8'h5A});
    w(8'h13, 8'h12);
    i_train_update = 1'b1;
    @(posedge i_clk);
    #1;
    i_train_update = 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    chk({tr_act, osc}, {1'b1, 8'h33});
    chk(per_us, 13'd500);
    w(8'h17, 8'h07);
    chk(per_us, 13'd4000);
    w(8'h13, 8'h00);
    chk({tr_act, smp, osc, per_us}, {2'b00, 8'h33, 13'd0});
    $display("Test command mode config done");
    w(8'h12, 8'h01);
    rchk(8'h12, 8'h01);
    chk({diag_m, cmd_m}, 2'b01);
    w(8'h15, 8'h7F);
    rchk(8'h15, 8'h00);
    w(8'h15, 8'h80);
    chk({cmd_m, per_m, diag_m, frag}, {3'b011, 3'h4});
    chk({locked, integ}, 2'b11);
    w(8'h15, 8'h00);
    rchk(8'h15, 8'h80);
    w(8'h13, 8'h03);
    rchk(8'h13, 8'h00);
    w(8'h11, 8'h05);
    rchk(8'h11, 8'h00);
    $display("Test periodic enable done");
    i_lock_user = 1'b1;
    do_reset();
    chk({per_m, slave_addr, disc}, {1'b0, 4'h9, 1'b0});
    rchk(8'h11, 8'h09);
    u_m.enter();
    repeat (2) @(posedge i_clk);
    #1;
    chk({per_m, cmd_m}, 2'b10);
    $display("Test lock and enter command done");
    conclude();
  end
endmodule : testbench
`default_nettype wire
